// ---- design/dsp_top.sv ----
// Purpose: APB register file and two serial slave port controllers
// Assumes: APB master holds request until pready; frame decoders external
// Notes:   all outputs registered; zero wait states on APB
//
// Register access over APB and the placing of the registers were left to the implementer.
`default_nettype none
module dsp_top
  import dsp_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = CLK_HZ
) (
  input  wire logic        ref_clk,    // 40 MHz clock
  input  wire logic        resetn,     // async reset, low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic [31:0]      prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error, unmapped
  input  wire logic [1:0]  busy,       // per port frame active
  input  wire dsp_evt_s    evt0,       // first port events
  input  wire dsp_evt_s    evt1,       // second port events
  output logic [31:0]      divOut,     // half-bit divisors, port1:port0
  output logic [1:0]       multiDrop,  // multi-drop driver per port
  output logic [1:0]       linkErrOut, // poll loss per port
  output logic             cmdOut      // command strobe, second port
);
  dsp_cfg_s    cfg0_ff, nxt_cfg0, cfg1_ff, nxt_cfg1, act0, act1;
  logic [15:0] tmo0_ff, nxt_tmo0, tmo1_ff, nxt_tmo1, div0, div1;
  logic [31:0] rd_ff, nxt_rd, dv_ff;
  logic        rdy_ff, nxt_rdy, err_ff, nxt_err, arst_ff, nxt_arst;
  logic [3:0]  exc0, exc1;
  logic        md0, md1, le0, le1, cmd0, cmd1;
  logic [1:0]  md_ff, le_ff;
  logic        cmd_ff;
  wire         setup = psel && !penable;
  wire         access = psel && penable && rdy_ff;

  // apb decode: answer in the access phase, one wait-free cycle
  always_comb begin
    nxt_cfg0 = cfg0_ff;
    nxt_cfg1 = cfg1_ff;
    nxt_tmo0 = tmo0_ff;
    nxt_tmo1 = tmo1_ff;
    nxt_arst = 1'b0;
    nxt_rdy  = setup;
    nxt_err  = 1'b0;
    nxt_rd   = 32'h0;
    if (setup) begin
      case (paddr)
        // config reads show the settings in force; they trail a write
        // for as long as a frame keeps the port busy
        OFS_CFG0: nxt_rd = {22'h0, act0};
        OFS_CFG1: nxt_rd = {22'h0, act1};
        OFS_TMO0: nxt_rd = {16'h0, tmo0_ff};
        OFS_TMO1: nxt_rd = {16'h0, tmo1_ff};
        OFS_STAT: nxt_rd = {22'h0, le1, le0, exc1, exc0}; // see (R8) (R11)
        OFS_CTRL: nxt_rd = 32'h0;
        default:  nxt_err = 1'b1;
      endcase
    end
    // writes land at the access edge that samples pready, never in setup
    if (access && pwrite) begin
      case (paddr)
        OFS_CFG0: nxt_cfg0 = dsp_cfg_s'(pwdata[9:0]);
        OFS_CFG1: nxt_cfg1 = dsp_cfg_s'(pwdata[9:0]);
        OFS_TMO0: nxt_tmo0 = pwdata[15:0];
        OFS_TMO1: nxt_tmo1 = pwdata[15:0];
        OFS_CTRL: nxt_arst = pwdata[0];                 // see (R14)
        default:  nxt_cfg0 = cfg0_ff;  // status is read only
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg0_ff <= dsp_cfg_s'(CFG_RST);
      cfg1_ff <= dsp_cfg_s'(CFG_RST);
      tmo0_ff <= TMO_RST;
      tmo1_ff <= TMO_RST;
      arst_ff <= 1'b0;
      rdy_ff  <= 1'b0;
      err_ff  <= 1'b0;
      rd_ff   <= 32'h0;
      dv_ff   <= 32'h0;
      md_ff   <= 2'h0;
      le_ff   <= 2'h0;
      cmd_ff  <= 1'b0;
    end else begin
      cfg0_ff <= nxt_cfg0;
      cfg1_ff <= nxt_cfg1;
      tmo0_ff <= nxt_tmo0;
      tmo1_ff <= nxt_tmo1;
      arst_ff <= nxt_arst;
      rdy_ff  <= nxt_rdy;
      err_ff  <= nxt_err;
      rd_ff   <= nxt_rd;
      dv_ff   <= {div1, div0};
      md_ff   <= {md1, md0};
      le_ff   <= {le1, le0};
      cmd_ff  <= cmd1;
    end
  end

  // only the second port takes commands
  dsp_port #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_port0 (
    .ref_clk(ref_clk), .resetn(resetn), .cfgReq(cfg0_ff), .tmoSec(tmo0_ff),
    .busy(busy[0]), .evt(evt0), .cmdAllow(1'b0), .alarmRst(arst_ff),
    .cfgAct(act0), .halfBitDiv(div0), .drvMulti(md0), .excCode(exc0),
    .linkErr(le0), .cmdStb(cmd0));                     // see (R9)
  dsp_port #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_port1 (
    .ref_clk(ref_clk), .resetn(resetn), .cfgReq(cfg1_ff), .tmoSec(tmo1_ff),
    .busy(busy[1]), .evt(evt1), .cmdAllow(1'b1), .alarmRst(arst_ff),
    .cfgAct(act1), .halfBitDiv(div1), .drvMulti(md1), .excCode(exc1),
    .linkErr(le1), .cmdStb(cmd1));

  assign prdata     = rd_ff;
  assign pready     = rdy_ff;
  assign pslverr    = err_ff;
  assign divOut     = dv_ff;
  assign multiDrop  = md_ff;
  assign linkErrOut = le_ff;
  assign cmdOut     = cmd_ff;

  a_apb_ready: assert property (@(posedge ref_clk) disable iff (!resetn)
    setup |=> pready) else $error("no ready after setup");
  a_port0_nocmd: assert property ( // see (R9)
    @(posedge ref_clk) disable iff (!resetn)
    !cmd0) else $error("first port issued command");
  a_rst_both: assert property ( // see (R14)
    @(posedge ref_clk) disable iff (!resetn)
    arst_ff && evt0 == '0 && evt1 == '0 |=>
    exc0 == EXC_NONE && exc1 == EXC_NONE)
    else $error("alarm reset not both ports");
  c_write: cover property (@(posedge ref_clk) disable iff (!resetn)
    setup && pwrite && paddr == OFS_CFG0);
  c_err: cover property (@(posedge ref_clk) disable iff (!resetn) pslverr);
endmodule
`default_nettype wire

// ---- design/dsp_pkg.sv ----
// Purpose: constants, types and register map of the dual serial slave port
// Assumes: 40 MHz ref_clk, APB slave with 32-bit data
// Notes:   Behaviour
// Behaviour
// (R1) line code 1/2/3 picks RS-232/422/485
// (R2) differential standards allow multi-drop tri-state driver
// (R3) baud codes 1..7 give 1200..38400
// (R4) configurer keeps equal baud codes at 19200+
// (R5) stop code 1/2/3 gives 1, 1.5, 2
// (R6) parity code 1/2/3 none, odd, even
// (R7) poll timeout in seconds raises poll loss
// (R8) both ports serve monitoring reads
// (R9) only second port accepts write commands
// (R10) framing setting picks ASCII or RTU
// (R11) read-only link error flag per port
// (R12) exception codes 0, 1, 2 reported
// (R13) local faults: 9 checksum, 10 garbled
// (R14) alarm reset clears both exception codes
// (R15) baud divisor from clock, change when idle
// (R16) valid query restarts timer, clears loss
`default_nettype none
package dsp_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [7:0] OFS_CFG0   = 8'h00;
  localparam logic [7:0] OFS_CFG1   = 8'h04;
  localparam logic [7:0] OFS_TMO0   = 8'h08;
  localparam logic [7:0] OFS_TMO1   = 8'h0c;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_CTRL   = 8'h14;
  // config word fields
  localparam int LINE_LSB = 0;
  localparam int BAUD_LSB = 2;
  localparam int STOP_LSB = 5;
  localparam int PAR_LSB  = 7;
  localparam int FRM_BIT  = 9;
  localparam logic [9:0]  CFG_RST  = 10'h0b5; // 232, 9600, 1 stop, none
  localparam logic [15:0] TMO_RST  = 16'h0005;
  localparam logic [3:0] EXC_NONE   = 4'h0;
  localparam logic [3:0] EXC_ILLFN  = 4'h1;
  localparam logic [3:0] EXC_ILLADR = 4'h2;
  localparam logic [3:0] EXC_CSUM   = 4'h9;
  localparam logic [3:0] EXC_GARBLE = 4'ha;
  typedef enum logic [1:0] {
    LS_RS232 = 2'b01, LS_RS422 = 2'b10, LS_RS485 = 2'b11
  } dsp_line_e;
  typedef struct packed {
    logic       framingRtu;   // protocol_framing_setting
    logic [1:0] parity;
    logic [1:0] stop;
    logic [2:0] baud;
    logic [1:0] line;
  } dsp_cfg_s;
  typedef struct packed {
    logic       queryOk;      // valid query addressed to device
    logic       isWrite;      // command acting on the device
    logic       crcBad;
    logic       garbled;
    logic       illFunc;
    logic       illAddr;
  } dsp_evt_s;
  // baud divisor in half-bit ticks, rounded to nearest
  function automatic logic [15:0] baudDiv(input logic [2:0] code);
    int unsigned b;
    case (code)
      3'h1: b = 1200;
      3'h2: b = 1800;
      3'h3: b = 2400;
      3'h4: b = 4800;
      3'h5: b = 9600;
      3'h6: b = 19200;
      3'h7: b = 38400;
      default: b = 9600;
    endcase
    return 16'((CLK_HZ + b) / (2 * b));
  endfunction
endpackage
`default_nettype wire

// ---- design/dsp_port.sv ----
// Purpose: one serial slave port: bit timing, poll-loss timer, status
// Assumes: query events arrive as one-cycle pulses from the frame decoder
// Notes:   config is latched only while the port is idle
`default_nettype none
module dsp_port
  import dsp_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = CLK_HZ
) (
  input  wire logic        ref_clk,     // system clock
  input  wire logic        resetn,      // async reset, low
  input  wire dsp_cfg_s    cfgReq,      // configuration from software
  input  wire logic [15:0] tmoSec,      // poll timeout in seconds
  input  wire logic        busy,        // frame in progress
  input  wire dsp_evt_s    evt,         // decoded frame events
  input  wire logic        cmdAllow,    // port may take write commands
  input  wire logic        alarmRst,    // clear exception code
  output dsp_cfg_s         cfgAct,      // configuration in force
  output logic [15:0]      halfBitDiv,  // clocks per half bit
  output logic             drvMulti,    // tri-state driver between frames
  output logic [3:0]       excCode,     // last exception code
  output logic             linkErr,     // poll loss flag
  output logic             cmdStb       // accepted write command
);
  // elaboration check: a zero tick count would never end a second
  if (TICKS_PER_SEC < 1) begin : g_badTicks
    $error("TICKS_PER_SEC must be positive");
  end
  dsp_cfg_s    cfg_ff, nxt_cfg;
  logic [31:0] tick_ff, nxt_tick;
  logic [15:0] sec_ff, nxt_sec;
  logic        loss_ff, nxt_loss;
  logic [3:0]  exc_ff, nxt_exc;
  logic        cmd_ff, nxt_cmd;

  // configuration, timer and status next values
  always_comb begin
    nxt_cfg  = busy ? cfg_ff : cfgReq;                // see (R15)
    nxt_tick = tick_ff + 32'h1;
    nxt_sec  = sec_ff;
    nxt_loss = loss_ff;
    nxt_exc  = exc_ff;
    nxt_cmd  = evt.queryOk && evt.isWrite && cmdAllow; // see (R9)
    if (tick_ff == 32'(TICKS_PER_SEC - 1)) begin      // see (R7)
      nxt_tick = 32'h0;
      if (sec_ff + 16'h1 >= tmoSec) nxt_loss = 1'b1;
      else nxt_sec = sec_ff + 16'h1;
    end
    if (evt.queryOk) begin                            // see (R16)
      nxt_tick = 32'h0;
      nxt_sec  = 16'h0;
      nxt_loss = 1'b0;
    end
    // clear first so a same-cycle fault survives the alarm reset
    if (alarmRst) nxt_exc = EXC_NONE;                 // see (R14)
    if (evt.illFunc) nxt_exc = EXC_ILLFN;             // see (R12)
    if (evt.illAddr) nxt_exc = EXC_ILLADR;            // see (R12)
    if (evt.queryOk && evt.isWrite && !cmdAllow)
      nxt_exc = EXC_ILLFN;                            // see (R9)
    if (evt.garbled) nxt_exc = EXC_GARBLE;            // see (R13)
    if (evt.crcBad) nxt_exc = EXC_CSUM;               // see (R13)
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff  <= dsp_cfg_s'(CFG_RST);
      tick_ff <= 32'h0;
      sec_ff  <= 16'h0;
      loss_ff <= 1'b0;
      exc_ff  <= EXC_NONE;
      cmd_ff  <= 1'b0;
    end else begin
      cfg_ff  <= nxt_cfg;
      tick_ff <= nxt_tick;
      sec_ff  <= nxt_sec;
      loss_ff <= nxt_loss;
      exc_ff  <= nxt_exc;
      cmd_ff  <= nxt_cmd;
    end
  end

  assign cfgAct     = cfg_ff;                         // see (R5) (R6) (R10)
  assign halfBitDiv = baudDiv(cfg_ff.baud);           // see (R3)
  assign drvMulti   = (cfg_ff.line == LS_RS422) ||
                      (cfg_ff.line == LS_RS485);      // see (R1) (R2)
  assign excCode    = exc_ff;
  assign linkErr    = loss_ff;                        // see (R11)
  assign cmdStb     = cmd_ff;

  a_cmd_gate: assert property ( // see (R9)
    @(posedge ref_clk) disable iff (!resetn)
    cmdStb |-> $past(cmdAllow)) else $error("command on monitor port");
  a_loss_clear: assert property ( // see (R16)
    @(posedge ref_clk) disable iff (!resetn)
    evt.queryOk |=> !linkErr) else $error("poll loss not cleared");
  a_cfg_hold: assert property ( // see (R15)
    @(posedge ref_clk) disable iff (!resetn)
    busy |=> $stable(cfgAct)) else $error("config changed in frame");
  a_crc_code: assert property ( // see (R13)
    @(posedge ref_clk) disable iff (!resetn)
    evt.crcBad |=> excCode == EXC_CSUM) else $error("crc code");
  a_rst_clear: assert property ( // see (R14)
    @(posedge ref_clk) disable iff (!resetn)
    alarmRst && evt == '0 |=> excCode == EXC_NONE)
    else $error("alarm reset missed");
  c_loss: cover property (@(posedge ref_clk) disable iff (!resetn)
    $rose(linkErr));
  c_cmd: cover property (@(posedge ref_clk) disable iff (!resetn) cmdStb);
endmodule
`default_nettype wire

// ---- verification/dsp_master_model.sv ----
// Purpose: stand-in for the remote protocol master and its frame decoder
// Assumes: each frame raises busy; frame ends with a one-cycle event pulse, hold with none
// Notes:   sends only the frames that a bench scenario asks for
`default_nettype none
module dsp_master_model
  import dsp_pkg::*;
(
  input  wire logic ref_clk, // system clock
  output logic [1:0] busy,   // frame in progress per port
  output dsp_evt_s   evt0,   // first port events
  output dsp_evt_s   evt1    // second port events
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle line: no frame, no event
  initial begin
    busy = 2'h0;
    evt0 = '0;
    evt1 = '0;
  end
  // busy covers the event so config never moves mid-frame
  task automatic frame(input int p, input dsp_evt_s e);
    @(posedge ref_clk);
    busy[p] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    if (p == 0) evt0 <= e;
    else evt1 <= e;
    @(posedge ref_clk);
    evt0 <= '0;
    evt1 <= '0;
    busy[p] <= 1'b0;
  endtask
  // a long frame with no event, to keep a port busy while software writes
  task automatic hold(input int p, input int n);
    @(posedge ref_clk);
    busy[p] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    busy[p] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the dual serial port config block
// Assumes: one second cut to 20 clocks
// Notes:   fixed waits after writes cover the idle-only config update
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsp_pkg::*;
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        cmdOut, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, divOut, rd;
  logic [1:0]  busy, multiDrop, linkErrOut;
  dsp_evt_s    evt0, evt1;
  int          miscompares, samplesChecked, cycles, cmdSeen;
  dsp_top #(.TICKS_PER_SEC(20)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .evt0(evt0), .evt1(evt1), .divOut(divOut),
    .multiDrop(multiDrop), .linkErrOut(linkErrOut), .cmdOut(cmdOut));
  dsp_master_model mst (.ref_clk(ref_clk), .busy(busy), .evt0(evt0),
    .evt1(evt1));
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard and command pulse counter
  always @(posedge ref_clk) begin
    cycles++;
    if (cmdOut === 1'b1) cmdSeen++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    samplesChecked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready is sampled high; only the cycle
  // ceiling ends a wait that never gets an answer
  task automatic apb(input logic        w,
                     input logic [7:0]  a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset();
    apb(0, OFS_CFG0, 0);
    chk("cfg0", rd, 32'(CFG_RST));
    chk("err", {31'h0, err}, 32'h0);
    apb(0, OFS_TMO1, 0);
    chk("tmo1", rd, 32'(TMO_RST));
    chk("div", divOut, 32'h08230823);
    chk("multi", {30'h0, multiDrop}, 32'h0);
    apb(0, 8'h18, 0);
    chk("unmapped", {31'h0, err}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_config();
    int rate[7] = '{1200, 1800, 2400, 4800, 9600, 19200, 38400};
    logic [31:0] w;
    for (int k = 1; k <= 7; k++) begin
      w = {22'h0, 1'(k), 2'((k + 1) % 3 + 1), 2'(k % 3 + 1), 3'(k),
           2'(k % 3 + 1)};
      apb(1, OFS_CFG1, w);
      repeat (3) @(posedge ref_clk);
      chk("div1", 32'(divOut[31:16]),
          (40000000 + rate[k-1]) / (2 * rate[k-1]));
      chk("multi", 32'(multiDrop[1]), 32'(k % 3 != 0));
      apb(0, OFS_CFG1, 0);
      chk("cfg1", rd, w);
    end
    // equal fast baud on both ports, first port on a shared line
    apb(1, OFS_CFG0, 32'h0bf);
    repeat (3) @(posedge ref_clk);
    chk("div", divOut, 32'h02090209);
    chk("multi", {30'h0, multiDrop}, 32'h3);
    // a write during a frame must wait until the port is idle again
    fork
      mst.hold(0, 12);
      begin
        apb(1, OFS_CFG0, 32'(CFG_RST));
        repeat (3) @(posedge ref_clk);
        chk("held", 32'(divOut[15:0]), 32'h209);
      end
    join
    repeat (3) @(posedge ref_clk);
    chk("idle", 32'(divOut[15:0]), 32'h823);
    chk("multi", {30'h0, multiDrop}, 32'h2);
    $display("test config done");
  endtask
  task automatic t_exc();
    logic [5:0] ev[4] = '{6'h08, 6'h04, 6'h02, 6'h01};
    logic [3:0] ex[4] = '{4'h9, 4'ha, 4'h1, 4'h2};
    for (int i = 0; i < 4; i++) begin
      mst.frame(1, dsp_evt_s'(ev[i]));
      repeat (2) @(posedge ref_clk);
      apb(0, OFS_STAT, 0);
      chk("exc1", 32'(rd[7:4]), 32'(ex[i]));
    end
    mst.frame(0, dsp_evt_s'(6'h08));
    repeat (2) @(posedge ref_clk);
    apb(0, OFS_STAT, 0);
    chk("exc0", 32'(rd[3:0]), 32'h9);
    apb(1, OFS_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    apb(1, OFS_STAT, 32'h3ff);
    apb(0, OFS_STAT, 0);
    chk("clear", 32'(rd[7:0]), 32'h0);
    chk("link", 32'(rd[9:8]), 32'h3);
    $display("test exception done");
  endtask
  task automatic t_cmd();
    int c;
    c = cmdSeen;
    mst.frame(1, dsp_evt_s'(6'h30));
    repeat (3) @(posedge ref_clk);
    chk("cmd1", cmdSeen - c, 1);
    mst.frame(0, dsp_evt_s'(6'h30));
    repeat (3) @(posedge ref_clk);
    chk("cmd0", cmdSeen - c, 1);
    apb(0, OFS_STAT, 0);
    chk("exc0", 32'(rd[7:0]), 32'h01);
    chk("link", 32'(rd[9:8]), 32'h0);
    $display("test command done");
  endtask
  task automatic t_link();
    apb(1, OFS_TMO0, 32'h2);
    apb(1, OFS_TMO1, 32'h2);
    mst.frame(0, dsp_evt_s'(6'h20));
    mst.frame(1, dsp_evt_s'(6'h20));
    repeat (30) @(posedge ref_clk);
    chk("link", 32'(linkErrOut), 32'h0);
    repeat (25) @(posedge ref_clk);
    chk("link", 32'(linkErrOut), 32'h3);
    mst.frame(0, dsp_evt_s'(6'h20));
    repeat (2) @(posedge ref_clk);
    chk("link", 32'(linkErrOut), 32'h2);
    $display("test link done");
  endtask
  // main sequence: reset for three clocks, then each scenario
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_config();
    t_exc();
    t_cmd();
    t_link();
    test_done();
  end
endmodule
`default_nettype wire
